// ### pkg/nmi_wakeup_pkg.sv
// constants, register map and carrier types of the interrupt and wakeup control block
// assumes one 250 MHz clock and an AHB-Lite register window of 256 bytes
package nmi_wakeup_pkg;
  // =========================================
  // interrupt source layout
  localparam int NUM_PERIPH = 111;
  localparam int NUM_EXT = 16;
  localparam int NUM_SW = 2;
  localparam int NUM_SRC = 129;
  localparam int IDX_W = 8;
  localparam int TFR_WORDS = 5;
  localparam int MAX_DMA = 8;
  // peripheral source indices used for wakeup
  localparam int PIDX_VDET1 = 0;
  localparam int PIDX_VDET2 = 1;
  localparam int PIDX_OSC = 2;
  localparam int PIDX_USB_RESUME = 3;
  localparam int PIDX_IWDOG = 4;
  localparam int PIDX_TIMER0 = 5;
  localparam int NUM_TMR = 4;
  // =========================================
  // non-maskable status / enable bit positions
  localparam int NMI_PIN_BIT = 0;
  localparam int NMI_OSC_BIT = 1;
  localparam int NMI_WDOG_BIT = 2;
  localparam int NMI_IWDOG_BIT = 3;
  localparam int NMI_VDET1_BIT = 4;
  localparam int NMI_VDET2_BIT = 5;
  localparam int NMI_RAM_BIT = 6;
  localparam int NMI_W = 7;
  // wake status bits
  localparam int WK_SLEEP_BIT = 0;
  localparam int WK_ALLSTOP_BIT = 1;
  localparam int WK_STANDBY_BIT = 2;
  localparam int WK_W = 3;
  localparam int SEL_EN_BIT = 15;
  // =========================================
  // register byte offsets
  localparam logic [7:0] OFS_NMI_STATUS = 8'h00;
  localparam logic [7:0] OFS_NMI_ENABLE = 8'h04;
  localparam logic [7:0] OFS_NMI_CLEAR = 8'h08;
  localparam logic [7:0] OFS_NMI_FLT_EN = 8'h0C;
  localparam logic [7:0] OFS_NMI_FLT_SET = 8'h10;
  localparam logic [7:0] OFS_NMI_EDGE = 8'h14;
  localparam logic [7:0] OFS_FAST_SEL = 8'h18;
  localparam logic [7:0] OFS_SW_TRIG = 8'h1C;
  localparam logic [7:0] OFS_WAKE_STATUS = 8'h20;
  localparam logic [7:0] OFS_WAKE_MASK = 8'h24;
  localparam logic [7:0] OFS_TFR_EN0 = 8'h40;
  localparam logic [7:0] OFS_DMA_SEL0 = 8'h60;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // =========================================
  // noise filter: sample period in clocks per setting, samples that must agree
  localparam logic [6:0] FLT_DIV0 = 7'h01;
  localparam logic [6:0] FLT_DIV1 = 7'h08;
  localparam logic [6:0] FLT_DIV2 = 7'h20;
  localparam logic [6:0] FLT_DIV3 = 7'h40;
  localparam int FLT_SAMPLES = 3;
  localparam logic NMI_PIN_IDLE = 1'b1;
  // =========================================
  typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_ALLSTOP, PM_STANDBY} pwr_mode_t;
  typedef struct packed {
    logic wr;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [7:0] raddr;
  } reg_bus_t;
endpackage

// ### verilog/ahb_reg_port.sv
// AHB-Lite slave front end: turns transfers into register strobes
// assumes single word transfers; always OKAY, zero wait states
`timescale 1ns/10ps
`default_nettype none
module ahb_reg_port (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // register side
  output nmi_wakeup_pkg::reg_bus_t bus,
  input wire logic [31:0] rd_word
);
  import nmi_wakeup_pkg::*;
  logic take;
  logic wr_pend_ff;
  logic [7:0] waddr_ff;
  logic [31:0] hrdata_ff;

  assign take = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign bus.wr = wr_pend_ff;
  assign bus.waddr = waddr_ff;
  assign bus.wdata = hwdata;
  assign bus.raddr = haddr[7:0];

  // =========================================
  // address phase capture
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_ff <= 1'b0;
      waddr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= take && hwrite && (hsize == 3'h2);
      waddr_ff <= haddr[7:0];
    end
  end

  // read data sampled at the address phase edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata_ff <= RST_WORD;
    end else begin
      hrdata_ff <= (take && !hwrite) ? rd_word : RST_WORD;
    end
  end
endmodule
`default_nettype wire

// ### verilog/nmi_pin_filter.sv
// NMI pin noise filter and edge detector
// assumes the pin is synchronous to mclk
`timescale 1ns/10ps
`default_nettype none
module nmi_pin_filter (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // pin and settings
  input wire logic pin,
  input wire logic flt_en,
  input wire logic [1:0] flt_sel,
  input wire logic rise_sel,
  // detected edge
  output logic edge_pulse
);
  import nmi_wakeup_pkg::*;
  logic [6:0] div_ff;
  logic [6:0] period;
  logic [FLT_SAMPLES-1:0] smp_ff;
  logic level_ff;
  logic prev_ff;
  logic edge_ff;
  logic tick;

  always_comb begin
    unique case (flt_sel)
      2'h0: period = FLT_DIV0;
      2'h1: period = FLT_DIV1;
      2'h2: period = FLT_DIV2;
      2'h3: period = FLT_DIV3;
    endcase
  end
  assign tick = (div_ff >= period - 7'h01);
  assign edge_pulse = edge_ff;

  // =========================================
  // sampling and majority-free agreement filter
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff <= 7'h00;
      smp_ff <= {FLT_SAMPLES{NMI_PIN_IDLE}};
      level_ff <= NMI_PIN_IDLE;
    end else begin
      div_ff <= tick ? 7'h00 : div_ff + 7'h01;
      if (!flt_en) begin
        level_ff <= pin;
        smp_ff <= {FLT_SAMPLES{pin}};
      end else if (tick) begin
        smp_ff <= {smp_ff[FLT_SAMPLES-2:0], pin};
        // level follows only after all samples agree
        if (&smp_ff) level_ff <= 1'b1;
        else if (~|smp_ff) level_ff <= 1'b0;
      end
    end
  end

  // edge of the chosen polarity
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_ff <= NMI_PIN_IDLE;
      edge_ff <= 1'b0;
    end else begin
      prev_ff <= level_ff;
      edge_ff <= rise_sel ? (level_ff && !prev_ff) : (!level_ff && prev_ff);
    end
  end
endmodule
`default_nettype wire

// ### verilog/nmi_wakeup_interrupt_control.sv
// interrupt routing, non-maskable collection and low power wakeup
// assumes level sources synchronous to mclk and a power mode from the system
//
// Function
// - only one source at a time may be chosen for the fast interrupt path.
// - any of 129 sources (111 peripheral, 16 pin, 2 software) can request the transfer controller.
// - a selected source can be forwarded as a start trigger to the DMA controller.
// - the NMI pin raises a non-maskable request on a software-chosen falling or rising edge.
// - an optional digital noise filter acts on the NMI pin before edge detection.
// - voltage detector one or two reports raise a non-maskable request.
// - main oscillator stop raises a non-maskable request.
// - system watchdog underflow or refresh error raises a non-maskable request.
// - independent watchdog underflow or refresh error raises its own non-maskable request.
// - RAM parity or ECC RAM error raises a non-maskable RAM error request.
// - sleep mode ends when any interrupt source becomes active.
// - clock stop ends on NMI pin, pin interrupt, detectors, osc stop, USB resume, watchdog or timers.
// - software standby ends only on NMI pin, pin interrupt, detectors, USB resume or watchdog.
// - each non-maskable source has a status flag, oscillation stop at bit 1.
// - each non-maskable source has an enable bit, oscillation stop at bit 1.
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module nmi_wakeup_interrupt_control #(
  parameter int NUM_DMA = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // interrupt sources
  input wire logic [nmi_wakeup_pkg::NUM_PERIPH-1:0] periph_irq,
  input wire logic [nmi_wakeup_pkg::NUM_EXT-1:0] ext_irq,
  // non-maskable sources
  input wire logic nmi_pin,
  input wire logic osc_stop,
  input wire logic wdog_event,
  input wire logic iwdog_event,
  input wire logic vdet1_event,
  input wire logic vdet2_event,
  input wire logic ram_error,
  // power state
  input wire nmi_wakeup_pkg::pwr_mode_t power_mode,
  // to CPU and transfer controllers
  output logic [nmi_wakeup_pkg::NUM_SRC-1:0] cpu_irq,
  output logic fast_irq,
  output logic nmi_req,
  output logic [nmi_wakeup_pkg::NUM_SRC-1:0] tfr_req,
  output logic [NUM_DMA-1:0] dma_trig,
  output logic wake_req,
  output logic irq
);
  import nmi_wakeup_pkg::*;

  if (NUM_DMA < 1 || NUM_DMA > MAX_DMA) begin : g_chk
    $error("NUM_DMA must be 1 to 8");
  end

  function automatic logic wr_hit(input reg_bus_t b, input logic [7:0] ofs);
    wr_hit = b.wr && (b.waddr == ofs);
  endfunction

  function automatic logic src_pick(input logic [NUM_SRC-1:0] v, input logic [IDX_W-1:0] i);
    src_pick = (i < IDX_W'(NUM_SRC)) ? v[i] : 1'b0;
  endfunction

  reg_bus_t bus;
  logic [31:0] rd_word;
  logic pin_edge;
  logic [NUM_SRC-1:0] src;
  logic [NUM_SRC-1:0] tfr_en_vec;
  logic [NUM_SRC-1:0] fast_vec;
  logic [NMI_W-1:0] nmi_evt;
  logic [WK_W-1:0] wake_evt;
  logic [NMI_W-1:0] nmi_st_ff;
  logic [NMI_W-1:0] nmi_en_ff;
  logic flt_en_ff;
  logic [1:0] flt_sel_ff;
  logic edge_rise_ff;
  logic fast_en_ff;
  logic [IDX_W-1:0] fast_idx_ff;
  logic [NUM_SW-1:0] sw_ff;
  logic [WK_W-1:0] wk_st_ff;
  logic [WK_W-1:0] wk_mask_ff;
  logic [31:0] tfr_en_ff [TFR_WORDS];
  logic [NUM_DMA-1:0] dma_en_ff;
  logic [IDX_W-1:0] dma_idx_ff [NUM_DMA];
  logic [NUM_SRC-1:0] cpu_irq_ff;
  logic [NUM_SRC-1:0] tfr_req_ff;
  logic [NUM_DMA-1:0] dma_trig_ff;
  logic fast_irq_ff;
  logic nmi_req_ff;
  logic wake_ff;
  logic irq_ff;
  logic pin_wake;
  logic common_wake;

  // =========================================
  // submodules
  ahb_reg_port u_bus (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .bus(bus),
    .rd_word(rd_word)
  );

  nmi_pin_filter u_flt (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin(nmi_pin),
    .flt_en(flt_en_ff),
    .flt_sel(flt_sel_ff),
    .rise_sel(edge_rise_ff),
    .edge_pulse(pin_edge)
  );

  // =========================================
  // source vector: peripheral, pin, software
  assign src = {sw_ff, ext_irq, periph_irq};

  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    assign tfr_en_vec[i] = tfr_en_ff[i / 32][i % 32];
    assign fast_vec[i] = fast_en_ff && (fast_idx_ff == IDX_W'(i));
  end

  // =========================================
  // configuration registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      nmi_en_ff <= '0;
      flt_en_ff <= 1'b0;
      flt_sel_ff <= 2'h0;
      edge_rise_ff <= 1'b0;
      wk_mask_ff <= '0;
    end else begin
      if (wr_hit(bus, OFS_NMI_ENABLE)) nmi_en_ff <= bus.wdata[NMI_W-1:0];
      if (wr_hit(bus, OFS_NMI_FLT_EN)) flt_en_ff <= bus.wdata[0];
      if (wr_hit(bus, OFS_NMI_FLT_SET)) flt_sel_ff <= bus.wdata[1:0];
      if (wr_hit(bus, OFS_NMI_EDGE)) edge_rise_ff <= bus.wdata[0];
      if (wr_hit(bus, OFS_WAKE_MASK)) wk_mask_ff <= bus.wdata[WK_W-1:0];
    end
  end

  // a single index register makes the fast path one source wide
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fast_en_ff <= 1'b0;
      fast_idx_ff <= '0;
    end else if (wr_hit(bus, OFS_FAST_SEL)) begin
      fast_en_ff <= bus.wdata[SEL_EN_BIT];
      fast_idx_ff <= bus.wdata[IDX_W-1:0];
    end
  end

  // software interrupts last one cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_ff <= '0;
    end else begin
      sw_ff <= wr_hit(bus, OFS_SW_TRIG) ? bus.wdata[NUM_SW-1:0] : '0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int w = 0; w < TFR_WORDS; w++) tfr_en_ff[w] <= RST_WORD;
    end else begin
      for (int w = 0; w < TFR_WORDS; w++) begin
        if (wr_hit(bus, OFS_TFR_EN0 + 8'(4 * w))) tfr_en_ff[w] <= bus.wdata;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dma_en_ff <= '0;
      for (int m = 0; m < NUM_DMA; m++) dma_idx_ff[m] <= '0;
    end else begin
      for (int m = 0; m < NUM_DMA; m++) begin
        if (wr_hit(bus, OFS_DMA_SEL0 + 8'(4 * m))) begin
          dma_en_ff[m] <= bus.wdata[SEL_EN_BIT];
          dma_idx_ff[m] <= bus.wdata[IDX_W-1:0];
        end
      end
    end
  end

  // =========================================
  // non-maskable collection
  always_comb begin
    nmi_evt = '0;
    nmi_evt[NMI_PIN_BIT] = pin_edge;
    nmi_evt[NMI_OSC_BIT] = osc_stop;
    nmi_evt[NMI_WDOG_BIT] = wdog_event;
    nmi_evt[NMI_IWDOG_BIT] = iwdog_event;
    nmi_evt[NMI_VDET1_BIT] = vdet1_event;
    nmi_evt[NMI_VDET2_BIT] = vdet2_event;
    nmi_evt[NMI_RAM_BIT] = ram_error;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      nmi_st_ff <= '0;
    end else if (wr_hit(bus, OFS_NMI_CLEAR)) begin
      nmi_st_ff <= (nmi_st_ff & ~bus.wdata[NMI_W-1:0]) | nmi_evt;
    end else begin
      nmi_st_ff <= nmi_st_ff | nmi_evt;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      nmi_req_ff <= 1'b0;
    end else begin
      nmi_req_ff <= |(nmi_st_ff & nmi_en_ff);
    end
  end

  // =========================================
  // request routing
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_irq_ff <= '0;
      tfr_req_ff <= '0;
      fast_irq_ff <= 1'b0;
      dma_trig_ff <= '0;
    end else begin
      cpu_irq_ff <= src & ~tfr_en_vec & ~fast_vec;
      tfr_req_ff <= src & tfr_en_vec;
      fast_irq_ff <= fast_en_ff && src_pick(src, fast_idx_ff);
      for (int m = 0; m < NUM_DMA; m++) begin
        dma_trig_ff[m] <= dma_en_ff[m] && src_pick(src, dma_idx_ff[m]);
      end
    end
  end

  // =========================================
  // wakeup
  assign pin_wake = nmi_st_ff[NMI_PIN_BIT] || (|ext_irq);
  assign common_wake = pin_wake || periph_irq[PIDX_VDET1] || periph_irq[PIDX_VDET2]
                       || periph_irq[PIDX_USB_RESUME] || periph_irq[PIDX_IWDOG];

  always_comb begin
    wake_evt = '0;
    unique case (power_mode)
      PM_RUN: wake_evt = '0;
      PM_SLEEP: wake_evt[WK_SLEEP_BIT] = (|src) || nmi_req_ff;
      PM_ALLSTOP: wake_evt[WK_ALLSTOP_BIT] = common_wake || periph_irq[PIDX_OSC]
                  || (|periph_irq[PIDX_TIMER0 +: NUM_TMR]);
      PM_STANDBY: wake_evt[WK_STANDBY_BIT] = common_wake;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_ff <= 1'b0;
      wk_st_ff <= '0;
    end else begin
      wake_ff <= |wake_evt;
      if (wr_hit(bus, OFS_WAKE_STATUS)) wk_st_ff <= (wk_st_ff & ~bus.wdata[WK_W-1:0]) | wake_evt;
      else wk_st_ff <= wk_st_ff | wake_evt;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) irq_ff <= 1'b0;
    else irq_ff <= |(wk_st_ff & wk_mask_ff);
  end

  // =========================================
  // read mux
  always_comb begin
    rd_word = RST_WORD;
    unique case (bus.raddr)
      OFS_NMI_STATUS: rd_word[NMI_W-1:0] = nmi_st_ff;
      OFS_NMI_ENABLE: rd_word[NMI_W-1:0] = nmi_en_ff;
      OFS_NMI_FLT_EN: rd_word[0] = flt_en_ff;
      OFS_NMI_FLT_SET: rd_word[1:0] = flt_sel_ff;
      OFS_NMI_EDGE: rd_word[0] = edge_rise_ff;
      OFS_FAST_SEL: rd_word = {16'h0000, fast_en_ff, 7'h00, fast_idx_ff};
      OFS_WAKE_STATUS: rd_word[WK_W-1:0] = wk_st_ff;
      OFS_WAKE_MASK: rd_word[WK_W-1:0] = wk_mask_ff;
      default: rd_word = RST_WORD;
    endcase
    for (int w = 0; w < TFR_WORDS; w++) begin
      if (bus.raddr == OFS_TFR_EN0 + 8'(4 * w)) rd_word = tfr_en_ff[w];
    end
    for (int m = 0; m < NUM_DMA; m++) begin
      if (bus.raddr == OFS_DMA_SEL0 + 8'(4 * m)) begin
        rd_word = {16'h0000, dma_en_ff[m], 7'h00, dma_idx_ff[m]};
      end
    end
  end

  assign cpu_irq = cpu_irq_ff;
  assign tfr_req = tfr_req_ff;
  assign fast_irq = fast_irq_ff;
  assign dma_trig = dma_trig_ff;
  assign nmi_req = nmi_req_ff;
  assign wake_req = wake_ff;
  assign irq = irq_ff;
endmodule
`default_nettype wire

// ### verif/nmi_wakeup_properties.sv
// concurrent checks on the ports of the interrupt and wakeup control block
// assumes the design package is compiled first; bound to the top module below
`timescale 1ns/10ps
`default_nettype none
module nmi_wakeup_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // sources and mode
  input wire logic [nmi_wakeup_pkg::NUM_PERIPH-1:0] periph_irq,
  input wire logic [nmi_wakeup_pkg::NUM_EXT-1:0] ext_irq,
  input wire nmi_wakeup_pkg::pwr_mode_t power_mode,
  // requests
  input wire logic [nmi_wakeup_pkg::NUM_SRC-1:0] cpu_irq,
  input wire logic [nmi_wakeup_pkg::NUM_SRC-1:0] tfr_req,
  input wire logic fast_irq,
  input wire logic nmi_req,
  input wire logic wake_req,
  input wire logic irq
);
  import nmi_wakeup_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic xfer;
  assign xfer = hsel && htrans[1];
  // =========================================
  // assertions
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_rdata_idle: assert property (!$past(xfer && !hwrite) |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_route_excl: assert property ((cpu_irq & tfr_req) == '0)
    else $error("source sent to cpu and transfer controller");
  a_route_cause: assert property (((cpu_irq | tfr_req) &
    ~{2'h3, $past(ext_irq), $past(periph_irq)}) == '0) else $error("request without source");
  a_fast_cause: assert property (fast_irq |-> $past(|periph_irq) || $past(|ext_irq) ||
    $past(xfer && hwrite, 3)) else $error("fast request without source");
  a_run_no_wake: assert property ($past(power_mode) == PM_RUN |-> !wake_req)
    else $error("wakeup while running");
  a_sleep_wake: assert property (power_mode == PM_SLEEP && |periph_irq |=> wake_req)
    else $error("sleep not ended");
  a_allstop_timer: assert property (power_mode == PM_ALLSTOP &&
    |periph_irq[PIDX_TIMER0+NUM_TMR-1:PIDX_TIMER0] |=> wake_req)
    else $error("clock stop not ended");
  a_standby_pin: assert property (power_mode == PM_STANDBY && |ext_irq |=> wake_req)
    else $error("standby not ended");
  a_nmi_sticky: assert property (nmi_req && !xfer && !$past(xfer) && !$past(xfer, 2)
    |=> nmi_req) else $error("nmi request dropped by itself");
  a_irq_sticky: assert property ((!xfer)[*3] ##0 irq |=> irq) else $error("irq dropped by itself");
  // =========================================
  // covers
  c_sleep_wake: cover property (power_mode == PM_SLEEP ##1 wake_req);
  c_nmi_rise: cover property ($rose(nmi_req));
  c_fast: cover property (fast_irq);
endmodule
bind nmi_wakeup_interrupt_control nmi_wakeup_checker chk (.mclk, .sys_rst, .hsel, .htrans,
  .hwrite, .hreadyout, .hresp, .hrdata, .periph_irq, .ext_irq, .power_mode, .cpu_irq,
  .tfr_req, .fast_irq, .nmi_req, .wake_req, .irq);
`default_nettype wire

// ### verif/power_mode_model.sv
// system side model: holds the power mode and leaves it on a wakeup request
// assumes mode requests from the bench as a one cycle strobe
`timescale 1ns/10ps
`default_nettype none
module power_mode_model (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // mode request
  input wire logic enter,
  input wire nmi_wakeup_pkg::pwr_mode_t mode_in,
  // wakeup
  input wire logic wake_req,
  output var nmi_wakeup_pkg::pwr_mode_t power_mode
);
  import nmi_wakeup_pkg::*;
  pwr_mode_t mode_ff;
  assign power_mode = mode_ff;
  // wakeup wins over a new request, as the core resumes first
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_ff <= PM_RUN;
    end else if (wake_req) begin
      mode_ff <= PM_RUN;
    end else if (enter) begin
      mode_ff <= mode_in;
    end
  end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench of the interrupt and wakeup control block
// assumes the package, design, checker and power mode model are compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import nmi_wakeup_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [NUM_PERIPH-1:0] periph_irq = '0;
  logic [NUM_EXT-1:0] ext_irq = '0;
  logic nmi_pin = 1'b1;
  logic [6:1] ev = '0;
  logic enter = 1'b0;
  pwr_mode_t mode_in = PM_RUN;
  pwr_mode_t power_mode;
  logic [NUM_SRC-1:0] cpu_irq;
  logic [NUM_SRC-1:0] tfr_req;
  logic fast_irq;
  logic nmi_req;
  logic wake_req;
  logic irq;
  logic [7:0] dma_trig;
  logic [31:0] rd;
  int fail_count = 0;
  int comparisons = 0;
  always #2 mclk = ~mclk;
  nmi_wakeup_interrupt_control #(.NUM_DMA(8)) uut (.mclk(mclk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .periph_irq(periph_irq), .ext_irq(ext_irq), .nmi_pin(nmi_pin),
    .osc_stop(ev[1]), .wdog_event(ev[2]), .iwdog_event(ev[3]), .vdet1_event(ev[4]),
    .vdet2_event(ev[5]), .ram_error(ev[6]), .power_mode(power_mode), .cpu_irq(cpu_irq),
    .fast_irq(fast_irq), .nmi_req(nmi_req), .tfr_req(tfr_req), .dma_trig(dma_trig),
    .wake_req(wake_req), .irq(irq));
  power_mode_model sysm (.mclk(mclk), .sys_rst(sys_rst), .enter(enter), .mode_in(mode_in),
    .wake_req(wake_req), .power_mode(power_mode));
  // =========================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // one single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic go_mode(input pwr_mode_t m);
    @(posedge mclk);
    mode_in <= m;
    enter <= 1'b1;
    @(posedge mclk);
    enter <= 1'b0;
    cyc(3);
  endtask
  task automatic wait_wake;
    for (int i = 0; i < 8 && wake_req !== 1'b1; i++) @(negedge mclk);
  endtask
  task automatic pin_to(input logic v, input logic [31:0] exp);
    @(posedge mclk);
    nmi_pin <= v;
    cyc(12);
    bus(1'b0, OFS_NMI_STATUS, 32'h0);
    check("pin status", rd, exp);
    bus(1'b1, OFS_NMI_CLEAR, 32'h1);
  endtask
  // =========================================
  // scenarios
  task automatic t_regs;
    bus(1'b0, OFS_NMI_STATUS, 32'h0);
    check("status reset", rd, RST_WORD);
    bus(1'b1, OFS_NMI_ENABLE, 32'h7F);
    bus(1'b0, OFS_NMI_ENABLE, 32'h0);
    check("enable", rd, 32'h7F);
    bus(1'b0, 8'hFC, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b0, OFS_NMI_CLEAR, 32'h0);
    check("clear reads", rd, 32'h0);
    bus(1'b1, OFS_NMI_FLT_SET, 32'h3);
    bus(1'b0, OFS_NMI_FLT_SET, 32'h0);
    check("filter set", rd, 32'h3);
  endtask
  task automatic t_nmi_events;
    for (int b = 1; b < NMI_W; b++) begin
      @(posedge mclk);
      ev[b] <= 1'b1;
      @(posedge mclk);
      ev[b] <= 1'b0;
      cyc(2);
      check("nmi_req", nmi_req, 32'h1);
      bus(1'b1, OFS_NMI_ENABLE, 32'h7F & ~(32'h1 << b));
      cyc(2);
      check("masked", nmi_req, 32'h0);
      bus(1'b0, OFS_NMI_STATUS, 32'h0);
      check("status", rd, 32'h1 << b);
      bus(1'b1, OFS_NMI_CLEAR, 32'h1 << b);
      bus(1'b1, OFS_NMI_ENABLE, 32'h7F);
      bus(1'b0, OFS_NMI_STATUS, 32'h0);
      check("cleared", rd, 32'h0);
    end
  endtask
  task automatic t_nmi_pin;
    pin_to(1'b0, 32'h1);
    bus(1'b1, OFS_NMI_EDGE, 32'h1);
    bus(1'b1, OFS_NMI_CLEAR, 32'h1);
    pin_to(1'b1, 32'h1);
    pin_to(1'b0, 32'h0);
    bus(1'b1, OFS_NMI_FLT_EN, 32'h1);
    bus(1'b1, OFS_NMI_FLT_SET, 32'h0);
    @(posedge mclk);
    nmi_pin <= 1'b1;
    pin_to(1'b0, 32'h0);
    pin_to(1'b1, 32'h1);
  endtask
  task automatic t_routing;
    @(posedge mclk);
    periph_irq[10] <= 1'b1;
    periph_irq[20] <= 1'b1;
    ext_irq[2] <= 1'b1;
    cyc(2);
    check("cpu ext", cpu_irq[113], 32'h1);
    bus(1'b1, OFS_TFR_EN0, 32'h400);
    bus(1'b1, OFS_TFR_EN0 + 8'h0C, 32'h0002_0000);
    bus(1'b1, OFS_FAST_SEL, 32'h8014);
    cyc(2);
    check("tfr", {tfr_req[113], tfr_req[10], cpu_irq[113], cpu_irq[10]}, 32'hC);
    check("fast", {fast_irq, cpu_irq[20]}, 32'h2);
    bus(1'b1, OFS_FAST_SEL, 32'h8015);
    cyc(2);
    check("fast moved", {fast_irq, cpu_irq[20]}, 32'h1);
    bus(1'b1, OFS_DMA_SEL0 + 8'h0C, 32'h8080);
    bus(1'b1, OFS_SW_TRIG, 32'h2);
    cyc(2);
    check("dma", {cpu_irq[128], dma_trig}, 32'h108);
    cyc(1);
    check("dma end", dma_trig, 32'h0);
    @(posedge mclk);
    periph_irq <= '0;
    ext_irq <= '0;
  endtask
  task automatic t_wake;
    bus(1'b1, OFS_WAKE_MASK, 32'h7);
    go_mode(PM_SLEEP);
    check("sleep idle", wake_req, 32'h0);
    @(posedge mclk);
    periph_irq[50] <= 1'b1;
    wait_wake();
    check("sleep wake", wake_req, 32'h1);
    @(posedge mclk);
    periph_irq[50] <= 1'b0;
    go_mode(PM_ALLSTOP);
    @(posedge mclk);
    periph_irq[PIDX_TIMER0 + 3] <= 1'b1;
    wait_wake();
    check("allstop wake", wake_req, 32'h1);
    @(posedge mclk);
    periph_irq <= '0;
    go_mode(PM_STANDBY);
    @(posedge mclk);
    periph_irq[PIDX_OSC] <= 1'b1;
    cyc(6);
    check("standby osc", {wake_req, power_mode}, {29'h0, 1'b0, PM_STANDBY});
    @(posedge mclk);
    ext_irq[3] <= 1'b1;
    wait_wake();
    check("standby wake", wake_req, 32'h1);
    @(posedge mclk);
    periph_irq <= '0;
    ext_irq <= '0;
    bus(1'b0, OFS_WAKE_STATUS, 32'h0);
    check("wake status", {irq, rd[30:0]}, 32'h8000_0007);
    bus(1'b1, OFS_WAKE_MASK, 32'h0);
    cyc(2);
    check("irq masked", irq, 32'h0);
    bus(1'b1, OFS_WAKE_MASK, 32'h7);
    bus(1'b1, OFS_WAKE_STATUS, 32'h7);
    cyc(2);
    check("irq cleared", irq, 32'h0);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // =========================================
  // main sequence and watchdog
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs();
    t_nmi_events();
    t_nmi_pin();
    t_routing();
    t_wake();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
